//--- rtl/dpll_reference_select_control.v
// Reference monitor, selector and loop control of a two-loop timing block
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// - Free-run to locked once any input with nonzero priority qualifies; here an input at priority 15 is never picked
// - Free-run output uses local oscillator only
// - Locked: average frequency over one second
// - Selected reference failure forces quick holdover
// - Holdover switches to another valid reference hitlessly
// - Revertive or nonrevertive selection is configurable
// - No valid input: stay in holdover
// - Monitor eight inputs for activity, frequency
// - Separate priority tables pick best per loop
// - Selected input divisible to loop rate
// - One missing cycle disqualifies the reference
// - Master clock is oscillator times sixteen
// - Watchdog flags local oscillator failure
// - Both loops lock at 8kHz multiples
// - Damping selectable: 1.2, 2.5, 5, 10, 20
// - Primary bandwidth 0.1-400Hz, acquisition and locked
// - Secondary bandwidth programmable 18Hz to 70Hz
// - Phase detector modes and multicycle range
// - Primary phase offset +-200ns in 6ps
// - Secondary bypass keeps monitoring, selection, division
// - Secondary tracks own input or primary
// - Secondary detector measures phase between inputs
`include "dpll_ref_sel_consts.vh"
module dpll_reference_select_control #(
	parameter AVG_CYC = `AVG_CYC,
	parameter LIM_W   = 16
) (
	// Clock, reset, enable
	input  wire                ref_clk,
	input  wire                srst,
	input  wire                ce,
	// APB slave
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output wire [31:0]         prdata,
	output wire                pready,
	output wire                pslverr,
	// Pins
	input  wire [`N_IN-1:0]    ref_in,
	input  wire                local_osc_clock,
	// Primary loop control
	output wire [1:0]          pri_state,
	output wire [2:0]          pri_sel,
	output wire                pri_use_osc,
	output reg  [LIM_W-1:0]    pri_freq_q,
	output reg                 pri_ref_div_q,
	output reg  [11:0]         pri_bw_q,
	output wire [2:0]          pri_damp,
	output wire [16:0]         pri_phase_off,
	// Secondary loop control
	output wire [1:0]          sec_mode,
	output wire [2:0]          sec_sel,
	output reg                 sec_ref_div_q,
	output reg                 sec_bypass_clk_q,
	output wire [6:0]          sec_bw,
	output wire [2:0]          sec_damp,
	// Shared detector and watchdog
	output wire [1:0]          pd_mode,
	output wire [12:0]         mc_range,
	output wire                osc_fail
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [31:0]          ctrl_q;
	reg  [31:0]          ptab_q;
	reg  [31:0]          stab_q;
	reg  [4*LIM_W-1:0]   lim_lo_q;
	reg  [4*LIM_W-1:0]   lim_hi_q;
	reg  [31:0]          div_q;
	reg  [20:0]          loop_q;
	reg  [23:0]          bw_q;
	reg  [14:0]          scfg_q;
	reg  [16:0]          phase_q;
	reg  [LIM_W-1:0]     hold_q;
	reg  [LIM_W-1:0]     meas_q;
	reg                  wdf_q;
	reg  [31:0]          prdata_q;
	reg                  rdy_q;
	reg  [1:0]           st_q;
	reg  [2:0]           psel_q;
	reg  [2:0]           ssel_q;
	reg                  has_avg_q;
	wire [`N_IN-1:0]     valid;
	wire [`N_IN-1:0]     edg;
	wire [8*LIM_W-1:0]   per_flat;
	wire [8*LIM_W-1:0]   lim_flat;
	reg  [31:0]          rd_mux;
	reg                  bad_addr;
	wire                 wr;
	wire                 revert;
	assign lim_flat = {lim_hi_q, lim_lo_q};
	assign revert   = ctrl_q[0];
	assign sec_mode = ctrl_q[2:1];
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [`N_IN-1:0] ri_s1_q;
	reg [`N_IN-1:0] ri_s2_q;
	reg [`N_IN-1:0] ri_s3_q;
	reg [2:0]       osc_s_q;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			ri_s1_q <= {`N_IN{1'b0}};
			ri_s2_q <= {`N_IN{1'b0}};
			ri_s3_q <= {`N_IN{1'b0}};
			osc_s_q <= 3'h0;
		end
		else if (ce)
		begin
			ri_s1_q <= ref_in;
			ri_s2_q <= ri_s1_q;
			ri_s3_q <= ri_s2_q;
			osc_s_q <= {osc_s_q[1:0], local_osc_clock};
		end
	end
	assign edg = ri_s2_q & ~ri_s3_q;
	// ----------------------------------------
	// Per-input activity and frequency monitor
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `N_IN; g = g + 1)
		begin : mon
			reg  [LIM_W-1:0] cnt_q;
			reg  [LIM_W-1:0] per_q;
			reg  [3:0]       qual_q;
			reg              vld_q;
			wire [LIM_W:0]   lim;
			wire [LIM_W:0]   cnt;
			assign lim = {1'b0, lim_flat[LIM_W*g +: LIM_W]};
			assign cnt = {1'b0, cnt_q};
			always @(posedge ref_clk)
			begin
				if (srst)
				begin
					cnt_q  <= {LIM_W{1'b0}};
					per_q  <= {LIM_W{1'b0}};
					qual_q <= 4'h0;
					vld_q  <= 1'b0;
				end
				else if (ce)
				begin
					if (edg[g])
					begin
						cnt_q <= {LIM_W{1'b0}};
						per_q <= cnt_q;
						// Period outside half to one and a half of nominal
						if (cnt < (lim >> 1) || cnt > lim + (lim >> 1))
						begin
							qual_q <= 4'h0;
							vld_q  <= 1'b0;
						end
						else if (qual_q == `QUAL_EDGES)
							vld_q <= 1'b1;
						else
							qual_q <= qual_q + 4'h1;
					end
					else
					begin
						if (cnt_q != {LIM_W{1'b1}})
							cnt_q <= cnt_q + {{(LIM_W-1){1'b0}}, 1'b1};
						if (cnt >= {lim[LIM_W-1:0], 1'b0})
						begin
							qual_q <= 4'h0;
							vld_q  <= 1'b0;
						end
					end
				end
			end
			assign valid[g] = vld_q;
			assign per_flat[LIM_W*g +: LIM_W] = per_q;
		end
	endgenerate
	// ----------------------------------------
	// Priority selection
	// ----------------------------------------
	// Priority 0 disables an input, 1 is highest; ties go to lower index
	function [3:0] pick;
		input [31:0]      tab;
		input [`N_IN-1:0] v;
		integer k;
		reg [3:0] bp;
		begin
			pick = 4'h0;
			bp   = 4'hf;
			for (k = 0; k < `N_IN; k = k + 1)
				if (v[k] && tab[4*k +: 4] != 4'h0 && tab[4*k +: 4] < bp)
				begin
					bp   = tab[4*k +: 4];
					pick = {1'b1, k[2:0]};
				end
		end
	endfunction
	wire [3:0] pbest;
	wire [3:0] sbest;
	assign pbest = pick(ptab_q, valid);
	assign sbest = pick(stab_q, valid);
	// ----------------------------------------
	// Primary loop state machine
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			st_q   <= `ST_FREE;
			psel_q <= 3'h0;
		end
		else if (ce)
		begin
			case (st_q)
				`ST_FREE:
					if (pbest[3])
					begin
						st_q   <= `ST_LOCK;
						psel_q <= pbest[2:0];
					end
				`ST_LOCK:
					if (!valid[psel_q])
						st_q <= `ST_HOLD;
					else if (revert && pbest[2:0] != psel_q)
						psel_q <= pbest[2:0];
				`ST_HOLD:
					// Stays here while nothing qualifies
					if (pbest[3])
					begin
						st_q   <= `ST_LOCK;
						psel_q <= pbest[2:0];
					end
				default:
					st_q <= `ST_FREE;
			endcase
		end
	end
	assign pri_state   = st_q;
	assign pri_sel     = psel_q;
	assign pri_use_osc = (st_q == `ST_FREE);
	// ----------------------------------------
	// Holdover averaging
	// ----------------------------------------
	// 2^AVG_SH samples spread over one second keep the divide a shift
	localparam SMP_CYC = AVG_CYC >> `AVG_SH;
	reg [31:0]               smp_q;
	reg [`AVG_SH-1:0]        n_q;
	reg [LIM_W+`AVG_SH-1:0]  acc_q;
	wire [LIM_W-1:0]         live;
	wire [LIM_W+`AVG_SH-1:0] acc_nx;
	assign live   = per_flat[LIM_W*psel_q +: LIM_W];
	assign acc_nx = acc_q + {{`AVG_SH{1'b0}}, live};
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			smp_q     <= 32'h0;
			n_q       <= {`AVG_SH{1'b0}};
			acc_q     <= {(LIM_W+`AVG_SH){1'b0}};
			hold_q    <= {LIM_W{1'b0}};
			has_avg_q <= 1'b0;
			pri_freq_q <= {LIM_W{1'b0}};
			pri_bw_q   <= `RST_BW;
		end
		else if (ce)
		begin
			if (st_q != `ST_LOCK)
			begin
				smp_q <= 32'h0;
				n_q   <= {`AVG_SH{1'b0}};
				acc_q <= {(LIM_W+`AVG_SH){1'b0}};
			end
			else if (smp_q == SMP_CYC - 1)
			begin
				smp_q <= 32'h0;
				n_q   <= n_q + {{(`AVG_SH-1){1'b0}}, 1'b1};
				if (&n_q)
				begin
					hold_q    <= acc_nx[LIM_W+`AVG_SH-1:`AVG_SH];
					has_avg_q <= 1'b1;
					acc_q     <= {(LIM_W+`AVG_SH){1'b0}};
				end
				else
					acc_q <= acc_nx;
			end
			else
				smp_q <= smp_q + 32'h1;
			case (st_q)
				`ST_LOCK: pri_freq_q <= live;
				`ST_HOLD: pri_freq_q <= hold_q;
				default:  pri_freq_q <= {LIM_W{1'b0}};
			endcase
			// Wide capture until the first average exists
			pri_bw_q <= (st_q == `ST_LOCK && has_avg_q) ? bw_q[23:12] : bw_q[11:0];
		end
	end
	// ----------------------------------------
	// Secondary selection, dividers, bypass
	// ----------------------------------------
	wire [2:0]       s_eff;
	wire             s_track;
	assign s_track = (sec_mode == `SM_TRACK);
	assign s_eff   = s_track ? psel_q : ssel_q;
	assign sec_sel = s_eff;
	reg [15:0] pdc_q;
	reg [15:0] sdc_q;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			ssel_q        <= 3'h0;
			pdc_q         <= 16'h0;
			sdc_q         <= 16'h0;
			pri_ref_div_q <= 1'b0;
			sec_ref_div_q <= 1'b0;
			sec_bypass_clk_q <= 1'b0;
		end
		else if (ce)
		begin
			if (sbest[3] && (revert || !valid[ssel_q]))
				ssel_q <= sbest[2:0];
			// Half period is div+1 input edges
			if (edg[psel_q])
			begin
				if (pdc_q >= div_q[15:0])
				begin
					pdc_q         <= 16'h0;
					pri_ref_div_q <= ~pri_ref_div_q;
				end
				else
					pdc_q <= pdc_q + 16'h1;
			end
			if (edg[s_eff])
			begin
				if (sdc_q >= div_q[31:16])
				begin
					sdc_q         <= 16'h0;
					sec_ref_div_q <= ~sec_ref_div_q;
				end
				else
					sdc_q <= sdc_q + 16'h1;
			end
			sec_bypass_clk_q <= (sec_mode == `SM_BYPASS) & sec_ref_div_q;
		end
	end
	// ----------------------------------------
	// Phase measurement between two inputs
	// ----------------------------------------
	reg [LIM_W-1:0] mcnt_q;
	reg             mrun_q;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			mcnt_q <= {LIM_W{1'b0}};
			mrun_q <= 1'b0;
			meas_q <= {LIM_W{1'b0}};
		end
		else if (ce)
		begin
			if (sec_mode != `SM_MEAS)
				mrun_q <= 1'b0;
			else if (edg[scfg_q[10:8]])
			begin
				mrun_q <= 1'b1;
				mcnt_q <= {LIM_W{1'b0}};
			end
			else if (mrun_q && edg[scfg_q[14:12]])
			begin
				mrun_q <= 1'b0;
				meas_q <= mcnt_q;
			end
			else if (mrun_q)
				mcnt_q <= mcnt_q + {{(LIM_W-1){1'b0}}, 1'b1};
		end
	end
	// ----------------------------------------
	// Oscillator watchdog
	// ----------------------------------------
	localparam [15:0] WDT_CYC = `WDT_CYC;
	reg [15:0] wd_q;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			wd_q  <= 16'h0;
			wdf_q <= 1'b0;
		end
		else if (ce)
		begin
			wd_q <= (osc_s_q[1] & ~osc_s_q[2]) ? 16'h0 : (wd_q == WDT_CYC ? wd_q : wd_q + 16'h1);
			// A new failure beats a clear in the same cycle
			if (wd_q == WDT_CYC)
				wdf_q <= 1'b1;
			else if (wr && paddr == `A_WDT_CLR && pwdata[0])
				wdf_q <= 1'b0;
		end
	end
	assign osc_fail = wdf_q;
	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign wr = psel & penable & pwrite & ce;
	always @*
	begin
		bad_addr = 1'b0;
		rd_mux   = 32'h0;
		case (paddr)
			`A_CTRL:     rd_mux = ctrl_q;
			`A_STATUS:   rd_mux = {8'h0, `MCLK_MULT, wdf_q, valid, sbest[3], s_eff,
			                       pbest[3], psel_q, st_q};
			`A_PRI_PRIO: rd_mux = ptab_q;
			`A_SEC_PRIO: rd_mux = stab_q;
			`A_LIM01:    rd_mux = lim_lo_q[31:0];
			`A_LIM23:    rd_mux = lim_lo_q[63:32];
			`A_LIM45:    rd_mux = lim_hi_q[31:0];
			`A_LIM67:    rd_mux = lim_hi_q[63:32];
			`A_DIV:      rd_mux = div_q;
			`A_LOOP:     rd_mux = {11'h0, loop_q};
			`A_PRI_BW:   rd_mux = {8'h0, bw_q};
			`A_SEC_CFG:  rd_mux = {17'h0, scfg_q};
			`A_PHASE:    rd_mux = {{15{phase_q[16]}}, phase_q};
			`A_HOLD:     rd_mux = {16'h0, hold_q};
			`A_MEAS:     rd_mux = {16'h0, meas_q};
			`A_WDT_CLR:  rd_mux = 32'h0;
			default:     bad_addr = 1'b1;
		endcase
	end
	// Read data is captured a cycle ahead so prdata comes from a flop
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			prdata_q <= 32'h0;
			rdy_q    <= 1'b0;
		end
		else if (ce)
		begin
			if (psel && !pwrite)
			begin
				prdata_q <= rd_mux;
				rdy_q    <= !(penable && rdy_q);
			end
			else
				rdy_q <= 1'b0;
		end
	end
	assign pready  = ce & (pwrite | rdy_q);
	assign pslverr = pready & penable & bad_addr;
	assign prdata  = prdata_q;
	// Out-of-range settings are clamped when written
	wire [2:0]  w_dp = pwdata[2:0] > `DAMP_MAX ? `DAMP_MAX : pwdata[2:0];
	wire [2:0]  w_ds = pwdata[5:3] > `DAMP_MAX ? `DAMP_MAX : pwdata[5:3];
	wire [12:0] w_mc = pwdata[20:8] > {1'b0, `MC_MAX} ? `MC_MAX : pwdata[20:8];
	wire [11:0] w_ba = pwdata[11:0] < `BW_MIN ? `BW_MIN : (pwdata[11:0] > `BW_MAX ? `BW_MAX : pwdata[11:0]);
	wire [11:0] w_bl = pwdata[23:12] < `BW_MIN ? `BW_MIN : (pwdata[23:12] > `BW_MAX ? `BW_MAX : pwdata[23:12]);
	wire [6:0]  w_sb = pwdata[6:0] < `SBW_MIN ? `SBW_MIN : (pwdata[6:0] > `SBW_MAX ? `SBW_MAX : pwdata[6:0]);
	wire signed [16:0] w_ph = pwdata[16:0];
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			ctrl_q   <= 32'h0;
			ptab_q   <= `RST_PRIO;
			stab_q   <= `RST_PRIO;
			lim_lo_q <= {4{`RST_LIM}};
			lim_hi_q <= {4{`RST_LIM}};
			div_q    <= 32'h0;
			loop_q   <= {13'h0, 2'h0, `RST_DAMP, `RST_DAMP};
			bw_q     <= {`RST_BW, `RST_BW};
			scfg_q   <= {8'h0, `RST_SEC_BW};
			phase_q  <= 17'h0;
		end
		else if (wr)
		begin
			case (paddr)
				`A_CTRL:     ctrl_q <= {29'h0, pwdata[2:0]};
				`A_PRI_PRIO: ptab_q <= pwdata;
				`A_SEC_PRIO: stab_q <= pwdata;
				`A_LIM01:    lim_lo_q[31:0] <= pwdata;
				`A_LIM23:    lim_lo_q[63:32] <= pwdata;
				`A_LIM45:    lim_hi_q[31:0] <= pwdata;
				`A_LIM67:    lim_hi_q[63:32] <= pwdata;
				`A_DIV:      div_q <= pwdata;
				`A_LOOP:     loop_q <= {w_mc, pwdata[7:6], w_ds, w_dp};
				`A_PRI_BW:   bw_q <= {w_bl, w_ba};
				`A_SEC_CFG:  scfg_q <= {pwdata[14:12], 1'b0, pwdata[10:8], 1'b0, w_sb};
				`A_PHASE:    phase_q <= (w_ph > $signed(`PH_MAX)) ? `PH_MAX :
				                        ((w_ph < -$signed(`PH_MAX)) ? (~`PH_MAX + 17'h1) : pwdata[16:0]);
				default:     ;
			endcase
		end
	end
	assign pri_damp      = loop_q[2:0];
	assign sec_damp      = loop_q[5:3];
	assign pd_mode       = loop_q[7:6];
	assign mc_range      = loop_q[20:8];
	assign sec_bw        = scfg_q[6:0];
	assign pri_phase_off = phase_q;
endmodule // dpll_reference_select_control

//--- rtl/dpll_ref_sel_consts.vh
// Constants for the reference select and loop control block
`ifndef DPLL_REF_SEL_CONSTS_VH
`define DPLL_REF_SEL_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define A_CTRL      8'h00
`define A_STATUS    8'h04
`define A_PRI_PRIO  8'h08
`define A_SEC_PRIO  8'h0c
`define A_LIM01     8'h10
`define A_LIM23     8'h14
`define A_LIM45     8'h18
`define A_LIM67     8'h1c
`define A_DIV       8'h20
`define A_LOOP      8'h24
`define A_PRI_BW    8'h28
`define A_SEC_CFG   8'h2c
`define A_PHASE     8'h30
`define A_HOLD      8'h34
`define A_MEAS      8'h38
`define A_WDT_CLR   8'h3c
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PRIO    32'h0000_0021
`define RST_LIM     16'h09c4
`define RST_BW      12'h00a
`define RST_SEC_BW  7'h12
`define RST_DAMP    3'h2
// ----------------------------------------
// Encodings and limits
// ----------------------------------------
`define N_IN        8
`define ST_FREE     2'h0
`define ST_LOCK     2'h1
`define ST_HOLD     2'h2
`define SM_INDEP    2'h0
`define SM_TRACK    2'h1
`define SM_BYPASS   2'h2
`define SM_MEAS     2'h3
`define DAMP_MAX    3'h4
`define BW_MIN      12'h001
`define BW_MAX      12'hfa0
`define SBW_MIN     7'h12
`define SBW_MAX     7'h46
`define MC_MAX      13'h1fff
`define PH_MAX      17'h0823d
`define MCLK_MULT   5'h10
`define QUAL_EDGES  4'h8
`define AVG_SH      10
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ      20000000
`define CLK_NS      50
`define AVG_TIME_MS 1000
`define WDT_TIME_NS 10000
`define AVG_CYC     (`AVG_TIME_MS * (`CLK_HZ / 1000))
`define WDT_CYC     (`WDT_TIME_NS / `CLK_NS)
`endif

//--- bench/dpll_ref_sel_props.sv
// Port checker for the reference select and loop control block
`timescale 1ns/100ps
`include "dpll_ref_sel_consts.vh"
module dpll_ref_sel_props #(
	parameter AVG_CYC = 10240,
	parameter LIM_W   = 16
) (
	// Clock and control
	input wire             ref_clk,
	input wire             srst,
	input wire             ce,
	// APB
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire [7:0]       paddr,
	input wire [31:0]      pwdata,
	input wire             pready,
	input wire             pslverr,
	// Loops and watchdog
	input wire [1:0]       pri_state,
	input wire [2:0]       pri_sel,
	input wire             pri_use_osc,
	input wire [LIM_W-1:0] pri_freq_q,
	input wire [11:0]      pri_bw_q,
	input wire [2:0]       pri_damp,
	input wire [1:0]       sec_mode,
	input wire [2:0]       sec_sel,
	input wire             sec_bypass_clk_q,
	input wire [6:0]       sec_bw,
	input wire             osc_fail
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire clr_wr = psel && penable && pwrite && ce && paddr == `A_WDT_CLR && pwdata[0];

	a_ready_ce: assert property (!ce |-> !pready) else $error("pready while frozen");
	a_err_unmapped: assert property (penable && pready && paddr > `A_WDT_CLR |-> pslverr) else $error("no pslverr");
	a_free_osc: assert property (pri_state == `ST_FREE |-> pri_use_osc && pri_freq_q == 0)
		else $error("free-run not on oscillator");
	a_reset_free: assert property (disable iff (1'b0) $fell(srst) |-> pri_state == `ST_FREE)
		else $error("not free-run after reset");
	a_never_free: assert property (!$past(srst) && $past(pri_state) != `ST_FREE |-> pri_state != `ST_FREE)
		else $error("returned to free-run");
	a_hold_frozen: assert property (pri_state == `ST_HOLD && $past(pri_state) == `ST_HOLD
		&& $past(pri_state, 2) == `ST_HOLD |-> $stable(pri_freq_q)) else $error("holdover value moved");
	a_track_sel: assert property (sec_mode == `SM_TRACK && $past(sec_mode) == `SM_TRACK
		&& $stable(pri_sel) |-> sec_sel == pri_sel) else $error("secondary not tracking");
	a_bypass_gate: assert property (!$past(srst) && sec_mode != `SM_BYPASS && $past(sec_mode) != `SM_BYPASS
		|-> !sec_bypass_clk_q) else $error("bypass clock leaks");
	a_damp_clamp: assert property (pri_damp <= `DAMP_MAX) else $error("damping out of set");
	a_bw_range: assert property (pri_bw_q >= `BW_MIN && pri_bw_q <= `BW_MAX) else $error("bandwidth range");
	a_sbw_range: assert property (sec_bw >= `SBW_MIN && sec_bw <= `SBW_MAX) else $error("sec bandwidth");
	a_osc_clear: assert property ($past(osc_fail) && !osc_fail |-> $past(clr_wr) || $past(srst))
		else $error("watchdog flag lost");

	c_lock: cover property (pri_state == `ST_LOCK);
	c_hold: cover property (pri_state == `ST_HOLD);
	c_wdt: cover property (osc_fail);
	c_bypass: cover property (sec_mode == `SM_BYPASS && sec_bypass_clk_q);
endmodule // dpll_ref_sel_props

bind dpll_reference_select_control dpll_ref_sel_props #(.AVG_CYC(AVG_CYC), .LIM_W(LIM_W)) u_props (
	.ref_clk(ref_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pri_state(pri_state),
	.pri_sel(pri_sel), .pri_use_osc(pri_use_osc), .pri_freq_q(pri_freq_q), .pri_bw_q(pri_bw_q),
	.pri_damp(pri_damp), .sec_mode(sec_mode), .sec_sel(sec_sel), .sec_bypass_clk_q(sec_bypass_clk_q),
	.sec_bw(sec_bw), .osc_fail(osc_fail));

//--- bench/ref_clock_farend.sv
// Far-side model: reference input clocks and local oscillator
`timescale 1ns/100ps
module ref_clock_farend #(
	parameter real HALF_NS     = 1250.0,
	parameter real OSC_HALF_NS = 39.1
) (
	// Control from bench
	input  wire       osc_run,
	input  wire [7:0] run,
	// Clocks towards the block
	output wire [7:0] ref_in,
	output reg        local_osc_clock
);
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_ref
			reg clk_q;
			assign ref_in[i] = clk_q;
			// Odd offset keeps edges clear of ref_clk edges
			initial
			begin
				clk_q = 1'b0;
				#(i * 110 + 7);
				forever
				begin
					#(HALF_NS);
					clk_q = run[i] ? ~clk_q : 1'b0;
				end
			end
		end
	endgenerate
	initial
	begin
		local_osc_clock = 1'b0;
		forever
		begin
			#(OSC_HALF_NS);
			local_osc_clock = osc_run ? ~local_osc_clock : local_osc_clock;
		end
	end
endmodule // ref_clock_farend

//--- bench/dpll_reference_select_control_test.sv
// Self-checking bench for the reference select and loop control block
`timescale 1ns/100ps
`include "dpll_ref_sel_consts.vh"
module dpll_reference_select_control_test;
	// Short averaging keeps the run brief
	localparam AVG = 10240;
	localparam PER = 50;
	reg         ref_clk = 1'b0;
	reg         srst = 1'b1;
	reg         ce = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [7:0]  run = 8'h00;
	reg         osc_run = 1'b1;
	reg  [31:0] lfsr = 32'h69f2ccbf;
	reg  [31:0] r;
	reg  [31:0] v;
	reg         e;
	integer     n_errors = 0;
	integer     n_checks = 0;
	integer     i;
	integer     cp;
	integer     cs;
	wire [31:0] prdata;
	wire        pready, pslverr, pri_use_osc, pri_ref_div_q, sec_ref_div_q, sec_bypass_clk_q, osc_fail;
	wire [1:0]  pri_state, sec_mode, pd_mode;
	wire [2:0]  pri_sel, pri_damp, sec_sel, sec_damp;
	wire [15:0] pri_freq_q;
	wire [11:0] pri_bw_q;
	wire [16:0] pri_phase_off;
	wire [6:0]  sec_bw;
	wire [12:0] mc_range;
	wire [7:0]  ref_in;
	wire        local_osc_clock;

	always #25 ref_clk = ~ref_clk;

	dpll_reference_select_control #(.AVG_CYC(AVG), .LIM_W(16)) DUT (
		.ref_clk(ref_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_in(ref_in), .local_osc_clock(local_osc_clock), .pri_state(pri_state), .pri_sel(pri_sel),
		.pri_use_osc(pri_use_osc), .pri_freq_q(pri_freq_q), .pri_ref_div_q(pri_ref_div_q),
		.pri_bw_q(pri_bw_q), .pri_damp(pri_damp), .pri_phase_off(pri_phase_off), .sec_mode(sec_mode),
		.sec_sel(sec_sel), .sec_ref_div_q(sec_ref_div_q), .sec_bypass_clk_q(sec_bypass_clk_q),
		.sec_bw(sec_bw), .sec_damp(sec_damp), .pd_mode(pd_mode), .mc_range(mc_range), .osc_fail(osc_fail));

	ref_clock_farend u_far (.osc_run(osc_run), .run(run), .ref_in(ref_in), .local_osc_clock(local_osc_clock));

	function [31:0] lfsr_next(input [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [31:0] clampu(input [31:0] x, input [31:0] lo, input [31:0] hi);
		clampu = x < lo ? lo : (x > hi ? hi : x);
	endfunction
	function [16:0] clamps(input [16:0] x);
		clamps = $signed(x) > $signed(`PH_MAX) ? `PH_MAX : ($signed(x) < -$signed(`PH_MAX) ? -`PH_MAX : x);
	endfunction

	task close_out;
		begin
			$display("Errors %0d checks %0d", n_errors, n_checks);
			if (n_errors == 0 && n_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp)
			begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One idle cycle between transfers avoids double drives
	task apb(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge ref_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			k = 0;
			@(negedge ref_clk);
			while (pready !== 1'b1 && k < 20)
			begin
				@(negedge ref_clk);
				k = k + 1;
			end
			chk(32'(k < 20), 32'h1);
			if (pready !== 1'b1)
				close_out;
			@(posedge ref_clk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd_chk(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk(r, exp);
		end
	endtask
	task wait_state(input [1:0] st, input integer lim);
		integer k;
		begin
			k = 0;
			@(negedge ref_clk);
			while (pri_state !== st && k < lim)
			begin
				@(negedge ref_clk);
				k = k + 1;
			end
			chk(32'(pri_state), 32'(st));
			if (pri_state !== st)
				close_out;
		end
	endtask
	task count_div(input integer cyc);
		integer k;
		reg p;
		reg s;
		begin
			cp = 0;
			cs = 0;
			@(negedge ref_clk);
			p = pri_ref_div_q;
			s = sec_bypass_clk_q;
			for (k = 0; k < cyc; k = k + 1)
			begin
				@(negedge ref_clk);
				cp = cp + (pri_ref_div_q !== p);
				cs = cs + (sec_bypass_clk_q !== s);
				p = pri_ref_div_q;
				s = sec_bypass_clk_q;
			end
		end
	endtask

	initial
	begin
		repeat (90000) @(posedge ref_clk);
		n_errors = n_errors + 1;
		$display("[ERR] %0t run too long", $time);
		close_out;
	end

	initial
	begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		// ----------------------------------------
		// Reset state and register defaults
		// ----------------------------------------
		rd_chk(`A_CTRL, 32'h0);
		rd_chk(`A_PRI_PRIO, `RST_PRIO);
		rd_chk(`A_SEC_PRIO, `RST_PRIO);
		rd_chk(`A_LIM01, {`RST_LIM, `RST_LIM});
		rd_chk(`A_STATUS, 32'h0080_0000);
		chk(32'(pri_use_osc), 32'h1);
		chk(32'(pri_bw_q), 32'(`RST_BW));
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(e), 32'h1);
		@(posedge ref_clk);
		ce <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ce <= 1'b1;
		// ----------------------------------------
		// Random loop fields, corners first
		// ----------------------------------------
		for (i = 0; i < 8; i = i + 1)
		begin
			lfsr = lfsr_next(lfsr);
			v = i == 0 ? 32'h0 : (i == 1 ? 32'hffff_ffff : lfsr);
			apb(1'b1, `A_LOOP, v);
			apb(1'b1, `A_SEC_CFG, v);
			apb(1'b1, `A_PHASE, v);
			@(negedge ref_clk);
			chk(32'(pri_damp), clampu(v[2:0], 0, 4));
			chk(32'(sec_damp), clampu(v[5:3], 0, 4));
			chk(32'({pd_mode, mc_range}), 32'({v[7:6], v[20:8]}));
			chk(32'(sec_bw), clampu(v[6:0], 18, 70));
			chk(32'(pri_phase_off), 32'(clamps(v[16:0])));
		end
		v = lfsr_next(lfsr);
		apb(1'b1, `A_PRI_BW, v);
		repeat (2) @(negedge ref_clk);
		chk(32'(pri_bw_q), clampu(v[11:0], 1, 4000));
		apb(1'b1, `A_LIM01, {16'd50, 16'd50});
		apb(1'b1, `A_DIV, {16'd1, 16'd4});
		// ----------------------------------------
		// Lock, averaging, failover
		// ----------------------------------------
		run <= 8'h03;
		wait_state(`ST_LOCK, 40 * PER);
		chk(32'(pri_sel), 32'h0);
		chk(32'(pri_use_osc), 32'h0);
		repeat (3 * PER) @(posedge ref_clk);
		chk(32'(pri_freq_q), PER - 1);
		apb(1'b1, `A_CTRL, 32'h1);
		apb(1'b1, `A_SEC_PRIO, 32'h12);
		repeat (4) @(posedge ref_clk);
		chk(32'(sec_sel), 32'h1);
		apb(1'b1, `A_CTRL, 32'h0);
		repeat (2 * AVG + 200) @(posedge ref_clk);
		rd_chk(`A_HOLD, PER - 1);
		chk(32'(pri_bw_q), clampu(v[23:12], 1, 4000));
		run <= 8'h02;
		wait_state(`ST_HOLD, 4 * PER);
		wait_state(`ST_LOCK, 40 * PER);
		chk(32'(pri_sel), 32'h1);
		@(posedge ref_clk);
		run <= 8'h03;
		repeat (20 * PER) @(posedge ref_clk);
		chk(32'(pri_sel), 32'h1);
		apb(1'b1, `A_CTRL, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk(32'(pri_sel), 32'h0);
		// ----------------------------------------
		// Secondary modes and dividers
		// ----------------------------------------
		for (i = 0; i < 4; i = i + 1)
		begin
			apb(1'b1, `A_CTRL, {29'h0, i[1:0], 1'b1});
			repeat (4) @(posedge ref_clk);
			chk(32'(sec_mode), i);
			if (i == 1)
				chk(32'(sec_sel), 32'h0);
			if (i == 3)
			begin
				apb(1'b1, `A_SEC_CFG, 32'h1012);
				repeat (4 * PER) @(posedge ref_clk);
				apb(1'b0, `A_MEAS, 32'h0);
				chk(32'(r > 0 && r < PER), 32'h1);
			end
			if (i == 2)
			begin
				count_div(20 * PER);
				chk(32'(cp >= 3 && cp <= 5), 32'h1);
				chk(32'(cs >= 9 && cs <= 11), 32'h1);
			end
		end
		// ----------------------------------------
		// All inputs lost, then oscillator stall
		// ----------------------------------------
		@(posedge ref_clk);
		run <= 8'h00;
		wait_state(`ST_HOLD, 4 * PER);
		repeat (10 * PER) @(posedge ref_clk);
		chk(32'(pri_state), 32'(`ST_HOLD));
		chk(32'(pri_freq_q), PER - 1);
		osc_run <= 1'b0;
		repeat (260) @(posedge ref_clk);
		chk(32'(osc_fail), 32'h1);
		apb(1'b0, `A_STATUS, 32'h0);
		chk(32'(r[18]), 32'h1);
		osc_run <= 1'b1;
		repeat (20) @(posedge ref_clk);
		apb(1'b1, `A_WDT_CLR, 32'h1);
		@(negedge ref_clk);
		chk(32'(osc_fail), 32'h0);
		close_out;
	end
endmodule // dpll_reference_select_control_test
